// ==== lcd_crt_display_timing_bench.sv ====
`timescale 1ns/10ps
module lcd_crt_display_timing_bench;
  // Host side pins, driven on the falling edge.
  logic clock = 0, rst = 1, ioSelN = 1, pWrN = 1, pRdN = 1, vSelN = 1, mWrN = 1, mRdN = 1;
  logic [3:0] portAddr = 0, portIndex;
  logic [13:0] memAddr = 0;
  logic [7:0] hostDataIn = 0, hostDataOut, upperByte, lowerByte;
  logic hostDataOeN, portWriteStrobe, portReadActive;
  lcdc_pkg::lcdc_panel_type panel;
  lcdc_pkg::lcdc_crt_type crt;
  int num_errors = 0, compares = 0, seed = 19836, rowCount, badRows;
  int lineNo = -1, wrPulses = 0;   // Raster lines seen, and register write pulses seen.
  logic hsPrev = 0, vstOn;         // Last sync level, and the expected vertical strobe.
  localparam int DOTS = 640;       // Dots per raster line given to the design.
  logic [7:0] mem [int];   // Behavioural picture of video memory.
  lcdc_display_timing u_lcdc_display_timing (.clock(clock), .rst(rst),
    .register_port_select_n(ioSelN), .port_write_n(pWrN), .port_read_n(pRdN), .portAddr(portAddr),
    .video_ram_select_n(vSelN), .mem_write_n(mWrN), .mem_read_n(mRdN), .memAddr(memAddr),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN), .portIndex(portIndex),
    .portWriteStrobe(portWriteStrobe), .portReadActive(portReadActive), .configuredDots(10'(DOTS)),
    .palMode(1'b0), .panel(panel), .crt(crt));
  lcdc_panel_model u_lcdc_panel_model (.panel(panel), .upperByte(upperByte), .lowerByte(lowerByte),
    .rowCount(rowCount), .badRows(badRows));
  initial forever #25 clock = ~clock;
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One memory cycle held four clocks; a read without select must leave the bus alone.
  task automatic memAcc(input logic wr, input logic sel, input logic [13:0] a, input logic [7:0] d);
    vSelN = !sel; memAddr = a; hostDataIn = d; mWrN = !wr; mRdN = wr;
    repeat (4) @(negedge clock);
    if (!wr) check(hostDataOeN, !sel);
    if (!wr && sel) check(hostDataOut, mem[a]);
    if (wr && sel) mem[a] = d;
    vSelN = 1; mWrN = 1; mRdN = 1;
    repeat (3) @(negedge clock);
  endtask
  // Write pulses of the register port, counted at the falling edge where they stand settled.
  always @(negedge clock) if (portWriteStrobe === 1'b1) wrPulses++;
  // Raster model: each sync rise opens a line, and the vertical pulses follow the line count.
  always @(negedge clock) begin
    if (!rst && crt.horizontal_sync && !hsPrev) begin
      lineNo++;
      vstOn = lineNo >= lcdc_pkg::VSTROBE_DELAY_LINES
              && lineNo < lcdc_pkg::VSTROBE_DELAY_LINES + lcdc_pkg::VSTROBE_LINES;
      check(crt.vertical_sync, lineNo < lcdc_pkg::VSYNC_LINES);
      check(crt.vertical_timing_strobe, vstOn);
    end
    hsPrev = crt.horizontal_sync;
  end
  initial begin
    logic [13:0] adr [8];
    int n;
    repeat (8) @(negedge clock);
    rst = 0;
    adr[0] = 14'd240; adr[1] = 14'd8240;
    for (int i = 2; i < 8; i++) adr[i] = 14'($random(seed));
    for (int i = 0; i < 8; i++) memAcc(1, 1, adr[i], 8'($random(seed)));
    memAcc(1, 0, adr[0], 8'h00);
    memAcc(0, 0, adr[0], 8'h00);
    for (int i = 0; i < 8; i++) memAcc(0, 1, adr[i], 8'h00);
    // A port write with a random index; the index must be taken while the strobe is held.
    ioSelN = 0; portAddr = 4'($random(seed)); pWrN = 0;
    repeat (4) @(negedge clock);
    check(portIndex, portAddr);
    ioSelN = 1; pWrN = 1;
    repeat (3) @(negedge clock);
    // A port read shows its level and takes its index, but must give no write pulse.
    ioSelN = 0; portAddr = 4'($random(seed)); pRdN = 0;
    repeat (4) @(negedge clock);
    check(portReadActive, 1'b1);
    check(portIndex, portAddr);
    ioSelN = 1; pRdN = 1;
    repeat (3) @(negedge clock);
    check(portReadActive, 1'b0);
    check(8'(wrPulses), 8'h01);
    for (int i = 0; i < 20000 && rowCount < 4; i++) @(negedge clock);
    check(rowCount >= 4, 1'b1);
    check(upperByte, mem[240]);
    check(lowerByte, mem[8240]);
    check(8'(badRows), 8'h00);
    // The first lit raster line opens the dot window, as wide as the configured dots ask.
    for (int i = 0; i < 60000 && crt.enable_window_clock !== 1'b1; i++) @(negedge clock);
    check(8'(lineNo), 8'(lcdc_pkg::TOP_DELAY_LINES + lcdc_pkg::TOP_BORDER_LINES));
    n = 0;
    while (crt.enable_window_clock === 1'b1 && n < 2000) begin
      n++;
      @(negedge clock);
    end
    check(8'(n - DOTS), 8'(DOTS / 8));
    stop_test;
  end
  // Cut a hang well after the first lit raster line should have been shown.
  initial begin
    #3500000;
    num_errors++;
    stop_test;
  end
endmodule

// ==== lcdc_display_timing.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Register port decoded from four address lines plus select.
// - Video memory is two 8K byte banks.
// - Host memory access anytime, display undisturbed.
// - Memory access needs select plus read or write.
// - Upper half nibble, high means white.
// - Lower half nibble, same polarity.
// - Data held stable around shift clock fall.
// - One row latch pulse per row.
// - Frame start pulse each display cycle.
// - Panel AC drive alternates, no DC bias.
// - Segment enable pulse per driver group.
// - Drives panel, intensity RGB and composite timing.
// - Line 63.695 us, active 35.7-44.7 us.
// - Frame 16.688 ms, active 12.2-13.0 ms.
// - Horizontal sync high 4.5 us.
// - Vertical sync high 196 us.
// - Burst 2.7 us, starting 0.8 us after sync, then border.
// - Vertical strobe 1019 us, 56 us delay.
// - Top border 764 us after sync; 64 us tail.
// - PAL frame 20 ms with longer borders.
// - Borders derived from configured dots per line.
// - Colours and window clock low near sync.
module lcdc_display_timing (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rst,
  // Host register port pins.
  input  wire logic               register_port_select_n,
  input  wire logic               port_write_n,
  input  wire logic               port_read_n,
  input  wire logic [3:0]         portAddr,
  // Host video memory pins.
  input  wire logic               video_ram_select_n,
  input  wire logic               mem_write_n,
  input  wire logic               mem_read_n,
  input  wire logic [13:0]        memAddr,
  // Host data bus, split into three signals.
  input  wire logic [7:0]         hostDataIn,
  output logic      [7:0]         hostDataOut,
  output logic                    hostDataOeN,
  // Register port decode results.
  output logic      [3:0]         portIndex,
  output logic                    portWriteStrobe,
  output logic                    portReadActive,
  // Configuration levels.
  input  wire logic [9:0]         configuredDots,
  input  wire logic               palMode,
  // Display pins.
  output lcdc_pkg::lcdc_panel_type panel,
  output lcdc_pkg::lcdc_crt_type   crt
);
  // True when a low select meets a low strobe.
  function automatic logic access_on(input logic selN, input logic strobeN);
    access_on = !selN && !strobeN;
  endfunction

  // Byte address of a column within an 80 byte line.
  function automatic logic [13:0] line_addr(input logic [7:0] line, input logic [6:0] col);
    line_addr = ({6'h00, line} << 6) + ({6'h00, line} << 4) + {7'h00, col};
  endfunction

  // Two-stage synchroniser for every host pin.
  logic [31:0] pinMeta_r;
  logic [31:0] pinSync_r;
  wire  [31:0] pinRaw = {register_port_select_n, port_write_n, port_read_n, video_ram_select_n,
                         mem_write_n, mem_read_n, portAddr, memAddr, hostDataIn};

  // Idle strobes are high, so reset loads ones.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinMeta_r <= '1;
      pinSync_r <= '1;
    end else begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  // Synchronised pin fields.
  wire        sPortSelN = pinSync_r[31];
  wire        sPortWrN  = pinSync_r[30];
  wire        sPortRdN  = pinSync_r[29];
  wire        sMemSelN  = pinSync_r[28];
  wire        sMemWrN   = pinSync_r[27];
  wire        sMemRdN   = pinSync_r[26];
  wire [3:0]  sPortAddr = pinSync_r[25:22];
  wire [13:0] sMemAddr  = pinSync_r[21:8];
  wire [7:0]  sData     = pinSync_r[7:0];
  wire        portWrOn  = access_on(sPortSelN, sPortWrN);
  wire        portRdOn  = access_on(sPortSelN, sPortRdN);
  wire        memWrOn   = access_on(sMemSelN, sMemWrN);
  wire        memRdOn   = access_on(sMemSelN, sMemRdN);

  // Host access state.
  logic        portWrOnD_r;
  logic [3:0]  portIndex_r;
  logic        memWrOnD_r;
  logic [13:0] wrAddr_r;
  logic [7:0]  wrData_r;
  wire         ramWrite = memWrOnD_r && !memWrOn;

  // Address and data are caught while the strobe is low and written at its end,
  // because the pins need not hold after the strobe rises.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portWrOnD_r <= 1'b0;
      portIndex_r <= '0;
      memWrOnD_r  <= 1'b0;
      wrAddr_r    <= '0;
      wrData_r    <= '0;
    end else begin
      portWrOnD_r <= portWrOn;
      memWrOnD_r  <= memWrOn;
      if (portWrOn || portRdOn) begin
        portIndex_r <= sPortAddr;
      end
      if (memWrOn) begin
        wrAddr_r <= sMemAddr;
        wrData_r <= sData;
      end
    end
  end

  assign portIndex       = portIndex_r;
  assign portWriteStrobe = portWrOn && !portWrOnD_r;
  assign portReadActive  = portRdOn;

  // Panel sequencer state.
  logic [11:0] rowCnt_r;
  logic [3:0]  shiftPhase_r;
  logic [7:0]  shiftIdx_r;
  logic [4:0]  segCnt_r;
  logic [6:0]  rowIdx_r;
  logic [7:0]  pendUpper_r;
  logic [7:0]  pendLower_r;
  logic [3:0]  upper_r;
  logic [3:0]  lower_r;
  logic        shiftClk_r;
  logic        latch_r;
  logic        frame_r;
  logic        acDrive_r;
  logic        segEn_r;
  logic [7:0]  panelData;

  // Row timing decode.
  wire        shifting  = rowCnt_r < 12'(lcdc_pkg::ROW_SHIFT_END);
  wire        rowEnd    = rowCnt_r == 12'(lcdc_pkg::ROW_CYCLES - 1);
  wire        phaseEnd  = shiftPhase_r == 4'(lcdc_pkg::SHIFT_PERIOD - 1);
  wire        lastRow   = rowIdx_r == 7'(lcdc_pkg::HALF_ROWS - 1);
  wire [6:0]  nextRow   = lastRow ? 7'h00 : rowIdx_r + 7'h01;
  wire [7:0]  nextShift = shiftIdx_r + 8'h01;
  wire [6:0]  fetchCol  = shifting ? nextShift[7:1] : 7'h00;
  wire [7:0]  upperLine = {1'b0, shifting ? rowIdx_r : nextRow};
  wire [7:0]  lowerLine = upperLine + 8'(lcdc_pkg::HALF_ROWS);
  wire [13:0] panelAddr = (shiftPhase_r == 4'h2) ? line_addr(upperLine, fetchCol)
                                                 : line_addr(lowerLine, fetchCol);
  wire        latchNxt  = rowCnt_r >= 12'(lcdc_pkg::LATCH_START) && rowCnt_r < 12'(lcdc_pkg::LATCH_END);
  wire        frameNxt  = lastRow && rowCnt_r >= 12'(lcdc_pkg::LATCH_START - lcdc_pkg::FRAME_SETUP)
                          && rowCnt_r < 12'(lcdc_pkg::LATCH_END + lcdc_pkg::FRAME_SETUP);
  wire        segNxt    = shifting && segCnt_r == 5'h00 && shiftPhase_r < 4'(lcdc_pkg::ENABLE_HIGH);

  // Row, shift and driver group counters.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rowCnt_r     <= '0;
      shiftPhase_r <= '0;
      shiftIdx_r   <= '0;
      segCnt_r     <= '0;
      rowIdx_r     <= '0;
    end else begin
      rowCnt_r     <= rowEnd ? 12'h000 : rowCnt_r + 12'h001;
      shiftPhase_r <= (rowEnd || phaseEnd) ? 4'h0 : shiftPhase_r + 4'h1;
      if (rowEnd) begin
        shiftIdx_r <= '0;
        segCnt_r   <= '0;
        rowIdx_r   <= nextRow;
      end else if (shifting && phaseEnd) begin
        shiftIdx_r <= nextShift;
        segCnt_r   <= (segCnt_r == 5'(lcdc_pkg::SEG_SHIFTS - 1)) ? 5'h00 : segCnt_r + 5'h01;
      end
    end
  end

  // Bytes for the next shift are fetched in phases two to four of the current one,
  // and during the row gap for shift zero, so a nibble is always ready.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendUpper_r <= '0;
      pendLower_r <= '0;
    end else begin
      if (shiftPhase_r == 4'h3) begin
        pendUpper_r <= panelData;
      end
      if (shiftPhase_r == 4'h4) begin
        pendLower_r <= panelData;
      end
    end
  end

  // Panel outputs; data changes on the same cycle the clock rises and holds past its fall.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upper_r    <= '0;
      lower_r    <= '0;
      shiftClk_r <= 1'b0;
      latch_r    <= 1'b0;
      frame_r    <= 1'b0;
      acDrive_r  <= 1'b0;
      segEn_r    <= 1'b0;
    end else begin
      if (shifting && shiftPhase_r == 4'h0) begin
        upper_r <= shiftIdx_r[0] ? pendUpper_r[3:0] : pendUpper_r[7:4];
        lower_r <= shiftIdx_r[0] ? pendLower_r[3:0] : pendLower_r[7:4];
      end
      shiftClk_r <= shifting && shiftPhase_r < 4'(lcdc_pkg::SHIFT_HIGH);
      latch_r    <= latchNxt;
      frame_r    <= frameNxt;
      acDrive_r  <= acDrive_r ^ (frame_r && !frameNxt);
      segEn_r    <= segNxt;
    end
  end

  // Raster state.
  logic [10:0] hCnt_r;
  logic [8:0]  vLine_r;
  logic [3:0]  dotSub_r;
  logic [9:0]  dotIdx_r;
  logic [2:0]  dotBitD_r;
  logic        showD_r;
  logic        hsync_r;
  logic        vsync_r;
  logic        vst_r;
  logic        burst_r;
  logic        enable_window_clock_r;
  logic        pixel_r;
  logic [7:0]  crtData;

  // Horizontal geometry follows the configured dot count.
  wire [10:0] activeCycles = 11'(configuredDots) + 11'(configuredDots >> 3);
  wire [10:0] leftWidth    = 11'((lcdc_pkg::LINE_CYCLES - lcdc_pkg::LEFT_BORDER_START
                             - lcdc_pkg::BORDER_TO_SYNC - int'(activeCycles)) / 2);
  wire [10:0] hActStart    = 11'(lcdc_pkg::LEFT_BORDER_START) + leftWidth;
  wire        hActive      = hCnt_r >= hActStart && hCnt_r < hActStart + activeCycles;
  wire        lineEnd      = hCnt_r == 11'(lcdc_pkg::LINE_CYCLES - 1);
  // Vertical geometry; PAL stretches the frame and the top border.
  wire [8:0]  frameLines   = palMode ? 9'(lcdc_pkg::PAL_FRAME_LINES)
                                     : 9'(lcdc_pkg::NTSC_FRAME_LINES);
  wire [8:0]  vActStart    = 9'(lcdc_pkg::TOP_DELAY_LINES + lcdc_pkg::TOP_BORDER_LINES)
                             + (palMode ? 9'(lcdc_pkg::PAL_TOP_EXTRA_LINES) : 9'h000);
  wire        vActive      = vLine_r >= vActStart && vLine_r < vActStart + 9'(lcdc_pkg::ACTIVE_LINES);
  wire        frameEnd     = vLine_r == frameLines - 9'h001;
  wire [8:0]  crtRow       = vLine_r - vActStart;
  wire [13:0] crtAddr      = line_addr(crtRow[7:0], dotIdx_r[9:3]);

  // One dot per cycle with a pause every ninth cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hCnt_r   <= '0;
      vLine_r  <= '0;
      dotSub_r <= '0;
      dotIdx_r <= '0;
    end else begin
      hCnt_r <= lineEnd ? 11'h000 : hCnt_r + 11'h001;
      if (lineEnd) begin
        vLine_r <= frameEnd ? 9'h000 : vLine_r + 9'h001;
      end
      if (lineEnd) begin
        dotSub_r <= '0;
        dotIdx_r <= '0;
      end else if (hActive) begin
        dotSub_r <= (dotSub_r == 4'h8) ? 4'h0 : dotSub_r + 4'h1;
        if (dotSub_r != 4'h8) begin
          dotIdx_r <= dotIdx_r + 10'h001;
        end
      end
    end
  end

  // Raster outputs, registered; colour lags by one cycle for the memory read.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dotBitD_r <= '0;
      showD_r   <= 1'b0;
      hsync_r   <= 1'b0;
      vsync_r   <= 1'b0;
      vst_r     <= 1'b0;
      burst_r   <= 1'b0;
      enable_window_clock_r    <= 1'b0;
      pixel_r   <= 1'b0;
    end else begin
      dotBitD_r <= dotIdx_r[2:0];
      showD_r   <= hActive && vActive;
      hsync_r   <= hCnt_r < 11'(lcdc_pkg::HSYNC_CYCLES);
      vsync_r   <= vLine_r < 9'(lcdc_pkg::VSYNC_LINES);
      vst_r     <= vLine_r >= 9'(lcdc_pkg::VSTROBE_DELAY_LINES)
                   && vLine_r < 9'(lcdc_pkg::VSTROBE_DELAY_LINES + lcdc_pkg::VSTROBE_LINES);
      burst_r   <= hCnt_r >= 11'(lcdc_pkg::HSYNC_CYCLES + lcdc_pkg::BURST_DELAY)
                   && hCnt_r < 11'(lcdc_pkg::HSYNC_CYCLES + lcdc_pkg::BURST_DELAY
                                   + lcdc_pkg::BURST_CYCLES);
      enable_window_clock_r    <= showD_r;
      pixel_r   <= showD_r && crtData[3'h7 - dotBitD_r];
    end
  end

  // Shared video memory; separate refresh ports keep host access invisible.
  lcdc_video_ram uRam (
    .clock         (clock),
    .hostAddr      (memWrOnD_r ? wrAddr_r : sMemAddr),
    .hostWrite     (ramWrite),
    .hostWriteData (wrData_r),
    .hostReadData  (hostDataOut),
    .panelAddr     (panelAddr),
    .panelReadData (panelData),
    .crtAddr       (crtAddr),
    .crtReadData   (crtData)
  );

  // The bus is driven only while a memory read is recognised.
  assign hostDataOeN = !memRdOn;

  // Pin packing for both display kinds.
  assign panel = '{upper_half_data: upper_r, lower_half_data: lower_r, pixel_shift_clock: shiftClk_r,
                   row_latch_pulse: latch_r, frame_start_pulse: frame_r, panel_ac_drive: acDrive_r,
                   segment_driver_enable: segEn_r};
  assign crt   = '{horizontal_sync: hsync_r, vertical_sync: vsync_r, vertical_timing_strobe: vst_r,
                   color_burst: burst_r, enable_window_clock: enable_window_clock_r, intensity_out: pixel_r,
                   red_out: pixel_r, green_out: pixel_r, blue_out: pixel_r};

  // Helper counters for the checks below.
  logic [7:0]  hsLen_r;
  logic [10:0] hsPeriod_r;
  logic        hsPrev_r;
  logic        lineSeen_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hsLen_r    <= '0;
      hsPeriod_r <= '0;
      hsPrev_r   <= 1'b0;
      lineSeen_r <= 1'b0;
    end else begin
      hsPrev_r   <= hsync_r;
      hsLen_r    <= hsync_r ? hsLen_r + 8'h01 : 8'h00;
      hsPeriod_r <= (hsync_r && !hsPrev_r) ? 11'h001 : hsPeriod_r + 11'h001;
      if (hsync_r && !hsPrev_r) begin
        lineSeen_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  port_write_pulse_a: assert property (portWriteStrobe |-> portWrOn ##1 !portWriteStrobe)
    else $error("port write strobe not a single pulse");
  vram_write_end_a: assert property (ramWrite |-> $past(memWrOn) && !memWrOn && !memRdOn)
    else $error("memory write outside strobe end");
  shift_data_hold_a: assert property ($fell(shiftClk_r) |-> $stable(upper_r) && $stable(lower_r)
                                      ##1 $stable(upper_r) && $stable(lower_r))
    else $error("panel data moved at shift clock fall");
  row_latch_width_a: assert property ($rose(latch_r) |-> latch_r [*7] ##1 !latch_r)
    else $error("row latch width wrong");
  frame_to_latch_a: assert property ($rose(frame_r) |-> ##7 $rose(latch_r))
    else $error("frame start not ahead of latch");
  ac_drive_sync_a: assert property ($changed(acDrive_r) |-> $fell(frame_r))
    else $error("AC drive toggled outside frame end");
  segment_enable_a: assert property ($rose(segEn_r) |-> segEn_r [*3] ##1 !segEn_r ##4 $fell(shiftClk_r))
    else $error("segment enable not ahead of shift fall");
  hsync_width_a: assert property ($fell(hsync_r) |-> hsLen_r == 8'(lcdc_pkg::HSYNC_CYCLES))
    else $error("horizontal sync width wrong");
  line_period_a: assert property ((hsync_r && !hsPrev_r && lineSeen_r)
                                  |-> hsPeriod_r == 11'(lcdc_pkg::LINE_CYCLES))
    else $error("line period wrong");
  burst_delay_a: assert property ($fell(hsync_r) |-> ##16 $rose(burst_r) ##1 burst_r [*8])
    else $error("colour burst misplaced");
  sync_blank_a: assert property (hsync_r |-> !pixel_r && !enable_window_clock_r)
    else $error("colour active during sync");

  frame_seen_c: cover property ($fell(frame_r));
  pal_frame_c: cover property ($rose(vsync_r) && palMode);
  host_write_c: cover property (ramWrite);
  host_read_c: cover property (memRdOn ##1 !memRdOn);
endmodule

// ==== lcdc_panel_model.sv ====
`timescale 1ns/10ps
module lcdc_panel_model (
  // Panel pins from the controller.
  input  wire lcdc_pkg::lcdc_panel_type panel,
  // First byte seen in each half of the last row, and row counts.
  output logic [7:0] upperByte,
  output logic [7:0] lowerByte,
  output int         rowCount,
  output int         badRows
);
  int shifts = 0;   // Shift edges seen in the current row.
  initial rowCount = 0;
  initial badRows = 0;
  // Both nibbles are taken only on the falling shift edge, high nibble first.
  always @(negedge panel.pixel_shift_clock) begin
    if (shifts == 0) begin
      upperByte[7:4] = panel.upper_half_data;
      lowerByte[7:4] = panel.lower_half_data;
    end
    if (shifts == 1) begin
      upperByte[3:0] = panel.upper_half_data;
      lowerByte[3:0] = panel.lower_half_data;
    end
    shifts++;
  end
  // A latch closes a row; the first row is skipped since reset may fake an edge.
  always @(posedge panel.row_latch_pulse) begin
    if (rowCount > 0 && shifts != lcdc_pkg::SHIFTS_PER_ROW) badRows++;
    rowCount++;
    shifts = 0;
  end
endmodule

// ==== lcdc_pkg.sv ====
package lcdc_pkg;
  // Base clock period.
  localparam int CLOCK_NS = 50;
  // Video memory: two banks of 8K bytes each.
  localparam int VRAM_BANK_BYTES = 8192;
  localparam int VRAM_BANKS      = 2;
  localparam int VRAM_ADDR_W     = 14;
  localparam int PORT_ADDR_W     = 4;
  // Panel geometry; each segment driver takes 80 dots.
  localparam int HALF_ROWS      = 100;
  localparam int ACTIVE_LINES   = 200;
  localparam int SHIFTS_PER_ROW = 160;
  localparam int SEG_SHIFTS     = 20;
  // Panel timing in ns, least values.
  localparam int SHIFT_CYCLE_NS    = 740;
  localparam int SHIFT_HIGH_NS     = 320;
  localparam int LATCH_HIGH_NS     = 320;
  localparam int FRAME_SETUP_NS    = 320;
  localparam int SHIFT_TO_LATCH_NS = 500;
  localparam int LATCH_TO_SHIFT_NS = 8000;
  localparam int ENABLE_HIGH_NS    = 140;
  // Least times round up to whole cycles.
  localparam int SHIFT_PERIOD   = (SHIFT_CYCLE_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SHIFT_HIGH     = (SHIFT_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int LATCH_HIGH     = (LATCH_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int FRAME_SETUP    = (FRAME_SETUP_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int SHIFT_TO_LATCH = (SHIFT_TO_LATCH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int LATCH_TO_SHIFT = (LATCH_TO_SHIFT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int ENABLE_HIGH    = (ENABLE_HIGH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int ROW_SHIFT_END  = SHIFTS_PER_ROW * SHIFT_PERIOD;
  localparam int LATCH_START    = ROW_SHIFT_END + SHIFT_TO_LATCH;
  localparam int LATCH_END      = LATCH_START + LATCH_HIGH;
  localparam int ROW_CYCLES     = LATCH_END + LATCH_TO_SHIFT;
  // Raster horizontal timing in ns.
  localparam int LINE_NS            = 63695;
  localparam int HSYNC_NS           = 4500;
  localparam int BURST_DELAY_NS     = 800;
  localparam int BURST_NS           = 2700;
  localparam int BURST_TO_BORDER_NS = 600;
  localparam int BORDER_TO_SYNC_NS  = 2500;
  localparam int LINE_CYCLES     = LINE_NS / CLOCK_NS;
  localparam int HSYNC_CYCLES    = HSYNC_NS / CLOCK_NS;
  localparam int BURST_DELAY     = (BURST_DELAY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int BURST_CYCLES    = BURST_NS / CLOCK_NS;
  localparam int BURST_TO_BORDER = (BURST_TO_BORDER_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int BORDER_TO_SYNC  = BORDER_TO_SYNC_NS / CLOCK_NS;
  localparam int LEFT_BORDER_START = HSYNC_CYCLES + BURST_DELAY + BURST_CYCLES + BURST_TO_BORDER;
  // Raster vertical timing in us, counted in whole lines.
  localparam int VSYNC_US         = 196;
  localparam int VSTROBE_US       = 1019;
  localparam int VSTROBE_DELAY_US = 56;
  localparam int TOP_DELAY_US     = 764;
  localparam int TOP_BORDER_US    = 1600;
  localparam int NTSC_FRAME_US    = 16688;
  localparam int PAL_FRAME_US     = 20000;
  localparam int PAL_TOP_EXTRA_US = 1700;

  // Converts a time in us to whole lines, never below one.
  function automatic int lines_of(input int us);
    int n;
    n = (us * 1000) / LINE_NS;
    return (n < 1) ? 1 : n;
  endfunction

  localparam int VSYNC_LINES         = lines_of(VSYNC_US);
  localparam int VSTROBE_LINES       = lines_of(VSTROBE_US);
  localparam int VSTROBE_DELAY_LINES = lines_of(VSTROBE_DELAY_US);
  localparam int TOP_DELAY_LINES     = lines_of(TOP_DELAY_US);
  localparam int TOP_BORDER_LINES    = lines_of(TOP_BORDER_US);
  localparam int NTSC_FRAME_LINES    = lines_of(NTSC_FRAME_US);
  localparam int PAL_FRAME_LINES     = lines_of(PAL_FRAME_US);
  localparam int PAL_TOP_EXTRA_LINES = lines_of(PAL_TOP_EXTRA_US);

  // Panel pins.
  typedef struct packed {
    logic [3:0] upper_half_data;
    logic [3:0] lower_half_data;
    logic       pixel_shift_clock;
    logic       row_latch_pulse;
    logic       frame_start_pulse;
    logic       panel_ac_drive;
    logic       segment_driver_enable;
  } lcdc_panel_type;

  // Monitor timing and colour pins.
  typedef struct packed {
    logic horizontal_sync;
    logic vertical_sync;
    logic vertical_timing_strobe;
    logic color_burst;
    logic enable_window_clock;
    logic intensity_out;
    logic red_out;
    logic green_out;
    logic blue_out;
  } lcdc_crt_type;
endpackage

// ==== lcdc_video_ram.sv ====
`timescale 1ns/10ps
module lcdc_video_ram (
  // Clock.
  input  wire logic       clock,
  // Host port.
  input  wire logic [13:0] hostAddr,
  input  wire logic        hostWrite,
  input  wire logic [7:0]  hostWriteData,
  output logic      [7:0]  hostReadData,
  // Refresh ports.
  input  wire logic [13:0] panelAddr,
  output logic      [7:0]  panelReadData,
  input  wire logic [13:0] crtAddr,
  output logic      [7:0]  crtReadData
);
  // Registered read data of each bank, per port.
  logic [7:0] bankHost  [lcdc_pkg::VRAM_BANKS];
  logic [7:0] bankPanel [lcdc_pkg::VRAM_BANKS];
  logic [7:0] bankCrt   [lcdc_pkg::VRAM_BANKS];
  // Bank choice of the last read, aligned with the data.
  logic       selHost_r;
  logic       selPanel_r;
  logic       selCrt_r;

  // Each bank has its own read port per client, so refresh never waits on the host.
  genvar b;
  generate
    for (b = 0; b < lcdc_pkg::VRAM_BANKS; b++) begin : gBank
      logic [7:0] mem [lcdc_pkg::VRAM_BANK_BYTES];
      wire        hit = (hostAddr[13] == 1'(b));
      // Write and three registered reads.
      always_ff @(posedge clock) begin
        if (hostWrite && hit) begin
          mem[hostAddr[12:0]] <= hostWriteData;
        end
        bankHost[b]  <= mem[hostAddr[12:0]];
        bankPanel[b] <= mem[panelAddr[12:0]];
        bankCrt[b]   <= mem[crtAddr[12:0]];
      end
    end
  endgenerate

  // Bank selects are registered with the data, one cycle after the address.
  always_ff @(posedge clock) begin
    selHost_r  <= hostAddr[13];
    selPanel_r <= panelAddr[13];
    selCrt_r   <= crtAddr[13];
  end

  assign hostReadData  = bankHost[selHost_r];
  assign panelReadData = bankPanel[selPanel_r];
  assign crtReadData   = bankCrt[selCrt_r];
endmodule
